// ==== core/hcd_ctx_onehot.sv ====
// One-hot context select built from a global context number
`timescale 1ns/1ps
module hcd_ctx_onehot
   import hcd_pkg::*;
(
   input  wire logic                          ctx_valid_i,
   input  wire logic [hcd_pkg::CTX_NUM_W-1:0] ctx_num_i,
   output      logic [hcd_pkg::CTX_TOTAL-1:0] ctx_hit_o
);

   // One comparator per implemented context
   genvar g;
   generate
      for (g = 0; g < CTX_TOTAL; g++)
      begin : g_ctx
         assign ctx_hit_o[g] = ctx_valid_i && (ctx_num_i == CTX_NUM_W'(g));
      end
   endgenerate

endmodule

// ==== core/hcd_decoder.sv ====
// Register space decoder for the host controller register window
//
// Summary of operation
// R01: All registers live inside one 2048-byte window and nothing outside it is decoded.
// R02: The host uses only single quadlet-wide, quadlet-aligned reads and writes.
// R03: The host never writes reserved locations because the effect is unpredictable.
// R04: A read of a reserved location returns a value nobody may rely on.
// R05: Offsets 11'h000 to 11'h17C are control registers, indexed by offset bits 8 to 2.
// R06: Offsets 11'h180 to 11'h1FC are async contexts, a two-bit context and three-bit register.
// R07: Offsets 11'h200 to 11'h3FC are iso transmit, a five-bit context and two-bit register.
// R08: Offsets from 11'h400 up are iso receive, a five-bit context and three-bit register.
// R09: Async select 2'h0 to 2'h3 are transmit request, transmit response, request and response receive.
// R10: Exactly four async contexts and 8 to 64 iso contexts exist, at most 68 in all.
// R11: The transmit select value is the iso transmit context number 0-31.
// R12: The receive select value is the iso receive context number 0-31.
// R13: No vendor registers exist; each window location is standard or reserved.
// R14: The two low offset bits take no part in register selection.
`timescale 1ns/1ps
module hcd_decoder
   import hcd_pkg::*;
(
   input  wire logic                          ref_clk_i,
   input  wire logic                          rst_n_i,
   input  wire logic                          req_valid_i,
   input  wire logic                          req_write_i,
   input  wire logic [hcd_pkg::ADDR_W-1:0]    req_addr_i,
   input  wire logic [3:0]                    req_byte_en_i,
   output      logic                          dec_valid_o,
   output      logic                          dec_write_o,
   output      hcd_pkg::hcd_region_t          dec_region_o,
   output      logic [hcd_pkg::CTX_NUM_W-1:0] dec_ctx_num_o,
   output      logic [hcd_pkg::CTX_TOTAL-1:0] dec_ctx_hit_o,
   output      logic [hcd_pkg::REG_IDX_W-1:0] dec_reg_index_o,
   output      logic                          dec_reserved_o,
   output      logic                          dec_misaligned_o,
   output      logic                          dec_write_blocked_o
);

   ////////////////////////////////////////////////////////////////////////////////////////
   // Reset release

   logic rst_meta_reg;
   logic rst_sync_reg;

   // Two stages so the release never lands near a clock edge
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic [OFS_W-1:0] ofs;
   logic             in_window;
   logic             is_ctrl;
   logic             is_async;
   logic             is_iso_tx;
   logic             is_iso_rx;
   logic [1:0]       async_context_select;
   logic [4:0]       iso_transmit_select;
   logic [4:0]       iso_rx_context_select;
   logic [6:0]       control_register_index;
   logic [2:0]       async_reg;
   logic [1:0]       iso_transmit_reg;
   logic [2:0]       iso_receive_reg;
   logic             it_ctx_present;
   logic             ir_ctx_present;

   // Upper address bits must match the window base exactly
   assign ofs         = req_addr_i[OFS_W-1:0];
   assign in_window   = (req_addr_i[ADDR_W-1:OFS_W] == WIN_BASE_ADDR[ADDR_W-1:OFS_W]); // [R01]

   // Region split on the top offset bits; together they cover every offset [R13]
   assign is_iso_rx   = ofs[10];                                              // [R08]
   assign is_iso_tx   = !ofs[10] && ofs[9];                                   // [R07]
   assign is_async    = !ofs[10] && !ofs[9] && (ofs[8:7] == 2'b11);           // [R06]
   assign is_ctrl     = !ofs[10] && !ofs[9] && (ofs[8:7] != 2'b11);           // [R05]

   // Select fields; bits 1:0 are never looked at [R14]
   assign control_register_index = ofs[CTRL_IDX_MSB:CTRL_IDX_LSB];            // [R05]
   assign async_context_select   = ofs[ASY_SEL_MSB:ASY_SEL_LSB];              // [R06]
   assign async_reg              = ofs[ASY_REG_MSB:ASY_REG_LSB];              // [R06]
   assign iso_transmit_select    = ofs[IT_SEL_MSB:IT_SEL_LSB];                // [R07]
   assign iso_transmit_reg       = ofs[IT_REG_MSB:IT_REG_LSB];                // [R07]
   assign iso_rx_context_select  = ofs[IR_SEL_MSB:IR_SEL_LSB];                // [R08]
   assign iso_receive_reg        = ofs[IR_REG_MSB:IR_REG_LSB];                // [R08]

   // Iso selects above the built population fall into reserved space
   assign it_ctx_present = ({2'b00, iso_transmit_select} < CTX_NUM_W'(IT_CTX_NUM));  // [R10]
   assign ir_ctx_present = ({2'b00, iso_rx_context_select} < CTX_NUM_W'(IR_CTX_NUM)); // [R10]

   ////////////////////////////////////////////////////////////////////////////////////////
   // Region, context number, register index and reserved flag

   hcd_region_t              region;
   logic [CTX_NUM_W-1:0]     ctx_num;
   logic                     ctx_valid;
   logic [REG_IDX_W-1:0]     reg_index;
   logic                     slot_impl;
   logic                     reserved;
   logic                     misaligned;

   // Region priority is irrelevant: the four terms are mutually exclusive
   assign region    = !in_window ? REGION_NONE   :
                      is_ctrl    ? REGION_CTRL   :
                      is_async   ? REGION_ASYNC  :
                      is_iso_tx  ? REGION_ISO_TX : REGION_ISO_RX;

   // Async numbers are the select itself, iso numbers follow in order [R09] [R11] [R12]
   assign ctx_num   = is_async  ? {5'h00, async_context_select}             :
                      is_iso_tx ? IT_CTX_BASE + {2'b00, iso_transmit_select} :
                      is_iso_rx ? IR_CTX_BASE + {2'b00, iso_rx_context_select} :
                                  7'h00;

   assign ctx_valid = in_window && (is_async || (is_iso_tx && it_ctx_present) ||
                                    (is_iso_rx && ir_ctx_present));            // [R10]

   assign reg_index = is_ctrl   ? control_register_index    :
                      is_async  ? {4'h0, async_reg}         :
                      is_iso_tx ? {5'h00, iso_transmit_reg} :
                                  {4'h0, iso_receive_reg};

   // Unused map slots are reserved; no vendor space hides in them [R13]
   assign slot_impl = is_ctrl   ? CTRL_IMPL_MASK[control_register_index] :
                      is_async  ? ASY_IMPL_MASK[async_reg]              :
                      is_iso_tx ? (IT_IMPL_MASK[iso_transmit_reg] && it_ctx_present) :
                                  (IR_IMPL_MASK[iso_receive_reg] && ir_ctx_present);

   // Reads of reserved slots are flagged, never given a defined value [R04]
   assign reserved   = !slot_impl;
   // Only whole aligned quadlets are legal host accesses [R02]
   assign misaligned = (req_addr_i[1:0] != QUAD_ALIGN) || (req_byte_en_i != QUAD_BYTE_EN);

   logic [CTX_TOTAL-1:0] ctx_hit;

   hcd_ctx_onehot u_ctx_onehot (
      .ctx_valid_i (ctx_valid),
      .ctx_num_i   (ctx_num),
      .ctx_hit_o   (ctx_hit)
   );

   ////////////////////////////////////////////////////////////////////////////////////////
   // Output stage

   logic                 take;
   logic                 wr_ok;
   logic                 valid_reg;
   logic                 write_reg;
   hcd_region_t          region_reg;
   logic [CTX_NUM_W-1:0] ctx_num_reg;
   logic [CTX_TOTAL-1:0] ctx_hit_reg;
   logic [REG_IDX_W-1:0] reg_index_reg;
   logic                 reserved_reg;
   logic                 misaligned_reg;
   logic                 wr_block_reg;

   // Out-of-window requests are simply not ours to answer [R01]
   assign take  = req_valid_i && in_window;
   // Writes to reserved or malformed slots are dropped to contain the damage [R03]
   assign wr_ok = req_write_i && !reserved && !misaligned;

   // Strobes last one cycle; decoded fields hold until the next accepted request
   always_ff @(posedge ref_clk_i or negedge rst_sync_reg)
   begin
      if (!rst_sync_reg)
      begin
         valid_reg      <= 1'b0;
         write_reg      <= 1'b0;
         wr_block_reg   <= 1'b0;
         region_reg     <= REGION_NONE;
         ctx_num_reg    <= '0;
         ctx_hit_reg    <= '0;
         reg_index_reg  <= '0;
         reserved_reg   <= 1'b0;
         misaligned_reg <= 1'b0;
      end
      else
      begin
         valid_reg    <= take;
         write_reg    <= take && wr_ok;
         wr_block_reg <= take && req_write_i && !wr_ok;
         if (take)
         begin
            region_reg     <= region;
            ctx_num_reg    <= ctx_num;
            ctx_hit_reg    <= ctx_hit;
            reg_index_reg  <= reg_index;
            reserved_reg   <= reserved;
            misaligned_reg <= misaligned;
         end
      end
   end

   assign dec_valid_o         = valid_reg;
   assign dec_write_o         = write_reg;
   assign dec_write_blocked_o = wr_block_reg;
   assign dec_region_o        = region_reg;
   assign dec_ctx_num_o       = ctx_num_reg;
   assign dec_ctx_hit_o       = ctx_hit_reg;
   assign dec_reg_index_o     = reg_index_reg;
   assign dec_reserved_o      = reserved_reg;
   assign dec_misaligned_o    = misaligned_reg;

   ////////////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (!rst_sync_reg);

   chk_window_only_valid: assert property ( // [R01]
      dec_valid_o |-> $past(req_valid_i) &&
         ($past(req_addr_i[ADDR_W-1:OFS_W]) == WIN_BASE_ADDR[ADDR_W-1:OFS_W]))
      else $error("decode strobe without an in-window request");

   chk_ctrl_region_index: assert property ( // [R05]
      take && (ofs <= CTRL_OFS_HI) |=> (dec_region_o == REGION_CTRL) &&
         (dec_reg_index_o == $past(req_addr_i[CTRL_IDX_MSB:CTRL_IDX_LSB])))
      else $error("control offset decoded wrongly");

   chk_async_region_ctx: assert property ( // [R06]
      take && (ofs >= ASY_OFS_LO) && (ofs <= ASY_OFS_HI) |=>
         (dec_region_o == REGION_ASYNC) && dec_ctx_num_o[6:2] == 5'h00 &&
         (dec_ctx_num_o[1:0] == $past(req_addr_i[ASY_SEL_MSB:ASY_SEL_LSB])))
      else $error("async offset decoded wrongly");

   chk_async_order_map: assert property ( // [R09]
      dec_valid_o && dec_ctx_hit_o[3:0] != 4'h0 |->
         dec_ctx_hit_o[dec_ctx_num_o[1:0]] && dec_region_o == REGION_ASYNC)
      else $error("async context order broken");

   chk_iso_tx_number: assert property ( // [R07] [R11]
      take && (ofs >= IT_OFS_LO) && (ofs <= IT_OFS_HI) |=>
         (dec_region_o == REGION_ISO_TX) &&
         (dec_ctx_num_o - IT_CTX_BASE == {2'b00, $past(req_addr_i[IT_SEL_MSB:IT_SEL_LSB])}))
      else $error("iso transmit context number wrong");

   chk_iso_rx_number: assert property ( // [R08] [R12]
      take && (ofs >= IR_OFS_LO) |=> (dec_region_o == REGION_ISO_RX) &&
         (dec_ctx_num_o - IR_CTX_BASE == {2'b00, $past(req_addr_i[IR_SEL_MSB:IR_SEL_LSB])}))
      else $error("iso receive context number wrong");

   chk_ctx_count_onehot: assert property ( // [R10]
      dec_valid_o |-> $onehot0(dec_ctx_hit_o) &&
         (dec_ctx_hit_o == '0 || dec_ctx_num_o < CTX_NUM_W'(CTX_TOTAL)))
      else $error("context select out of population");

   chk_full_map_cover: assert property ( // [R13]
      dec_valid_o |-> dec_region_o != REGION_NONE)
      else $error("in-window offset left undecoded");

   chk_low_bits_ignored: assert property ( // [R14]
      take && $past(take) && (ofs[10:2] == $past(ofs[10:2])) |=>
         (dec_reg_index_o == $past(dec_reg_index_o)) &&
         (dec_ctx_num_o == $past(dec_ctx_num_o)))
      else $error("low offset bits changed the selection");

   chk_write_guard_drop: assert property ( // [R03] [R04]
      take && req_write_i && (reserved || misaligned) |=>
         !dec_write_o && dec_write_blocked_o)
      else $error("reserved or malformed write passed on");

   // Idle cycles must leave region, context hits, register index and reserved flag untouched, so a stale decode is never re-announced
   chk_idle_levels_hold: assert property ( // [R01]
      !take |=> !dec_valid_o && $stable(dec_region_o) && $stable(dec_ctx_hit_o) &&
         $stable(dec_reg_index_o) && $stable(dec_reserved_o))
      else $error("decode outputs moved without an accepted request");

   chk_write_strobe_excl: assert property ( // [R03]
      (dec_write_o || dec_write_blocked_o) |->
         dec_valid_o && !(dec_write_o && dec_write_blocked_o))
      else $error("write strobes out of step with the decode strobe");

   chk_quad_form_flag: assert property ( // [R02]
      take |=> dec_misaligned_o == (($past(req_addr_i[1:0]) != QUAD_ALIGN) ||
         ($past(req_byte_en_i) != QUAD_BYTE_EN)))
      else $error("quadlet form flag wrong");

   chk_ctrl_no_context: assert property ( // [R05]
      take && is_ctrl |=> dec_ctx_hit_o == '0)
      else $error("control access selected a context");

   chk_iso_tx_absent: assert property ( // [R10] [R11]
      take && is_iso_tx && (ofs[IT_SEL_MSB:IT_SEL_LSB] >= 5'(IT_CTX_NUM)) |=>
         dec_reserved_o && (dec_ctx_hit_o == '0))
      else $error("absent iso transmit context not reserved");

   chk_iso_rx_absent: assert property ( // [R10] [R12]
      take && is_iso_rx && (ofs[IR_SEL_MSB:IR_SEL_LSB] >= 5'(IR_CTX_NUM)) |=>
         dec_reserved_o && (dec_ctx_hit_o == '0))
      else $error("absent iso receive context not reserved");

endmodule

// ==== core/hcd_pkg.sv ====
// Constants and types shared by the host controller register space decoder
package hcd_pkg;

   // Window geometry
   localparam int          WIN_BYTES      = 2048;
   localparam int          ADDR_W         = 32;
   localparam int          OFS_W          = 11;
   localparam logic [31:0] WIN_BASE_ADDR  = 32'h0001_0000;  // Window base on the system bus

   // Region boundaries (byte offsets inside the window)
   localparam logic [10:0] CTRL_OFS_LO    = 11'h000;
   localparam logic [10:0] CTRL_OFS_HI    = 11'h17C;
   localparam logic [10:0] ASY_OFS_LO     = 11'h180;
   localparam logic [10:0] ASY_OFS_HI     = 11'h1FC;
   localparam logic [10:0] IT_OFS_LO      = 11'h200;
   localparam logic [10:0] IT_OFS_HI      = 11'h3FC;
   localparam logic [10:0] IR_OFS_LO      = 11'h400;
   localparam logic [10:0] IR_OFS_HI      = 11'h7FC;

   // Field positions inside the offset
   localparam int          CTRL_IDX_LSB   = 2;
   localparam int          CTRL_IDX_MSB   = 8;
   localparam int          ASY_SEL_LSB    = 5;
   localparam int          ASY_SEL_MSB    = 6;
   localparam int          ASY_REG_LSB    = 2;
   localparam int          ASY_REG_MSB    = 4;
   localparam int          IT_SEL_LSB     = 4;
   localparam int          IT_SEL_MSB     = 8;
   localparam int          IT_REG_LSB     = 2;
   localparam int          IT_REG_MSB     = 3;
   localparam int          IR_SEL_LSB     = 5;
   localparam int          IR_SEL_MSB     = 9;
   localparam int          IR_REG_LSB     = 2;
   localparam int          IR_REG_MSB     = 4;

   // Asynchronous context numbers
   localparam logic [1:0]  ASY_TX_REQ     = 2'h0;
   localparam logic [1:0]  ASY_TX_RESP    = 2'h1;
   localparam logic [1:0]  ASY_RX_REQ     = 2'h2;
   localparam logic [1:0]  ASY_RX_RESP    = 2'h3;

   // Context population: four async plus sixteen isochronous (range 8 to 64)
   localparam int          ASY_CTX_NUM    = 4;
   localparam int          IT_CTX_NUM     = 8;
   localparam int          IR_CTX_NUM     = 8;
   localparam int          CTX_TOTAL      = ASY_CTX_NUM + IT_CTX_NUM + IR_CTX_NUM;
   localparam int          CTX_NUM_W      = 7;
   localparam int          REG_IDX_W      = 7;
   localparam logic [6:0]  IT_CTX_BASE    = 7'h04;
   localparam logic [6:0]  IR_CTX_BASE    = 7'h0C;

   // Implemented register maps; a clear bit marks a reserved slot
   localparam logic [95:0] CTRL_IMPL_MASK = 96'h0000_00FF_1F00_0FFF_F631_E7FF;
   localparam logic [7:0]  ASY_IMPL_MASK  = 8'h0B;
   localparam logic [3:0]  IT_IMPL_MASK   = 4'hB;
   localparam logic [7:0]  IR_IMPL_MASK   = 8'h1B;

   // Quadlet access
   localparam logic [3:0]  QUAD_BYTE_EN   = 4'hF;
   localparam logic [1:0]  QUAD_ALIGN     = 2'h0;

   typedef enum logic [2:0] {
      REGION_NONE,
      REGION_CTRL,
      REGION_ASYNC,
      REGION_ISO_TX,
      REGION_ISO_RX
   } hcd_region_t;

endpackage

// ==== verification/hcd_decoder_tb.sv ====
// Self-checking bench for the register space decoder against an integer model
`timescale 1ns/1ps
module hcd_decoder_tb;
   import hcd_pkg::*;
   typedef struct {logic v; logic w; logic [31:0] a; logic [3:0] be;} hcd_req_t;

   logic                ref_clk_i = 1'b0;
   logic                rst_n_i   = 1'b0;
   logic                req_valid, req_write;
   logic [31:0]         req_addr;
   logic [3:0]          req_be;
   logic                dec_valid, dec_write, dec_res, dec_mis, dec_blk;
   hcd_region_t         dec_region, e_region;
   logic [6:0]          dec_ctx, dec_reg, e_ctx, e_reg;
   logic [CTX_TOTAL-1:0] dec_hit, e_hit;
   logic                e_res, e_mis, win, known, mon_on;
   hcd_req_t            q[$];
   hcd_req_t            r;
   int                  n_fail, checked, cyc, ofs, c, base, i;
   logic [15:0]         rnd;

   hcd_decoder hcd_decoder_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .req_valid_i(req_valid), .req_write_i(req_write), .req_addr_i(req_addr),
      .req_byte_en_i(req_be), .dec_valid_o(dec_valid), .dec_write_o(dec_write),
      .dec_region_o(dec_region), .dec_ctx_num_o(dec_ctx), .dec_ctx_hit_o(dec_hit),
      .dec_reg_index_o(dec_reg), .dec_reserved_o(dec_res), .dec_misaligned_o(dec_mis),
      .dec_write_blocked_o(dec_blk));

   hcd_host_model hcd_host_model_inst (.ref_clk_i(ref_clk_i), .req_valid_o(req_valid),
      .req_write_o(req_write), .req_addr_o(req_addr), .req_byte_en_o(req_be));

   always #5 ref_clk_i = ~ref_clk_i;

   //////////////////////////////////////////////////////////////////////////////////
   // Comparison, verdict and helpers
   task automatic chk(input logic [63:0] e, input logic [63:0] g);
      checked++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask

   task automatic summarize();
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   function automatic logic [15:0] lfsr(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction

   // Implemented control slots; everything else in that region is reserved
   function automatic bit ctrl_impl(input int o);
      return (o <= 'h028) || (o >= 'h034 && o <= 'h040) || (o >= 'h050 && o <= 'h054) ||
             (o >= 'h064 && o <= 'h068) || (o >= 'h070 && o <= 'h0AC) ||
             (o >= 'h0E0 && o <= 'h0F0) || (o >= 'h100 && o <= 'h11C);
   endfunction

   //////////////////////////////////////////////////////////////////////////////////
   // Capture each sampled request; hang guard
   always @(posedge ref_clk_i)
   begin
      cyc++;
      if (mon_on)
         q.push_back('{req_valid, req_write, req_addr, req_be});
      if (cyc == 6000)
      begin
         n_fail++;
         summarize();
      end
   end

   // Model the decode of the request taken one edge earlier and compare every output
   always @(negedge ref_clk_i)
   begin
      if (mon_on && q.size() > 0)
      begin
         r   = q.pop_front();
         win = (r.a[31:11] == WIN_BASE_ADDR[31:11]);
         if (r.v && win)
         begin
            ofs   = int'(r.a[10:0]);
            e_mis = (ofs % 4 != 0) || (r.be != 4'hF);
            e_hit = '0;
            known = 1'b1;
            base  = (ofs >= 'h400) ? 12 : 4;
            if (ofs >= 'h400)
            begin
               e_region = REGION_ISO_RX;
               c        = (ofs >> 5) & 31;
               e_reg    = 7'((ofs >> 2) & 7);
               e_res    = !(e_reg inside {0, 1, 3, 4});
            end
            else if (ofs >= 'h200)
            begin
               e_region = REGION_ISO_TX;
               c        = (ofs >> 4) & 31;
               e_reg    = 7'((ofs >> 2) & 3);
               e_res    = (e_reg == 2);
            end
            else if (ofs >= 'h180)
            begin
               e_region = REGION_ASYNC;
               c        = (ofs >> 5) & 3;
               base     = 0;
               e_reg    = 7'((ofs >> 2) & 7);
               e_res    = !(e_reg inside {0, 1, 3});
            end
            else
            begin
               e_region = REGION_CTRL;
               e_reg    = 7'((ofs >> 2) & 127);
               e_res    = !ctrl_impl(ofs & 'h7FC);
               known    = 1'b0;
            end
            if (e_region != REGION_CTRL && c < 8)
            begin
               e_ctx            = 7'(base + c);
               e_hit[base + c]  = 1'b1;
            end
            else if (e_region != REGION_CTRL)
            begin
               e_res = 1'b1;
               known = 1'b0;
            end
         end
         chk(r.v && win, dec_valid);
         chk(r.v && win && r.w && !e_res && !e_mis, dec_write);
         chk(r.v && win && r.w && (e_res || e_mis), dec_blk);
         chk(e_region, dec_region);
         chk(e_reg, dec_reg);
         chk(e_res, dec_res);
         chk(e_mis, dec_mis);
         chk(e_hit, dec_hit);
         if (known)
            chk(e_ctx, dec_ctx);
      end
   end

   //////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial
   begin
      {n_fail, checked, cyc} = '0;
      mon_on   = 1'b0;
      rnd      = 16'h0002;
      e_region = REGION_NONE;
      {e_ctx, e_reg, e_hit, e_res, e_mis} = '0;
      repeat (20) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
      chk(0, {dec_valid, dec_write, dec_region, dec_ctx, dec_hit, dec_reg, dec_res,
              dec_mis, dec_blk});
      rst_n_i = 1'b1;
      repeat (3) @(negedge ref_clk_i);
      mon_on = 1'b1;
      // Every quadlet of the window read, then written, back to back (reserved included)
      for (i = 0; i < 1024; i++)
         hcd_host_model_inst.quad(i[9], WIN_BASE_ADDR + 32'((i % 512) * 4));
      // Low offset bits and partial lanes: decoded, flagged, writes dropped
      for (i = 1; i < 16; i++)
         hcd_host_model_inst.access(i[0], WIN_BASE_ADDR + 32'h18C + 32'(i % 4),
                                    4'(15 - i % 5));
      // Just outside the window on both sides
      hcd_host_model_inst.quad(1'b1, WIN_BASE_ADDR + 32'h800);
      hcd_host_model_inst.quad(1'b0, WIN_BASE_ADDR - 32'h4);
      hcd_host_model_inst.release_bus();
      // Random traffic with gaps, odd lanes and stray window bases
      for (i = 0; i < 400; i++)
      begin
         rnd = lfsr(rnd);
         if (rnd[15:14] == 2'b00)
            hcd_host_model_inst.release_bus();
         else
            hcd_host_model_inst.access(rnd[11],
               {WIN_BASE_ADDR[31:12], rnd[13:12] == 2'b01, rnd[10:0]},
               rnd[12] ? 4'hF : rnd[15:12]);
      end
      hcd_host_model_inst.release_bus();
      repeat (3) @(negedge ref_clk_i);
      summarize();
   end
endmodule

// ==== verification/hcd_host_model.sv ====
// Behavioural host processor issuing register requests into the decoder window
`timescale 1ns/1ps
module hcd_host_model
   import hcd_pkg::*;
(
   input  wire logic        ref_clk_i,
   output      logic        req_valid_o,
   output      logic        req_write_o,
   output      logic [31:0] req_addr_o,
   output      logic [3:0]  req_byte_en_o
);
   // Quiet bus at time zero
   initial
   begin
      req_valid_o   = 1'b0;
      req_write_o   = 1'b0;
      req_addr_o    = 32'h0000_0000;
      req_byte_en_o = 4'h0;
   end

   //////////////////////////////////////////////////////////////////////////////////
   // One request per call; valid stays up so calls may follow back to back
   task automatic access(input logic w, input logic [31:0] a, input logic [3:0] be);
      @(negedge ref_clk_i);
      req_valid_o   = 1'b1;
      req_write_o   = w;
      req_addr_o    = a;
      req_byte_en_o = be;
   endtask

   // Well-formed access: quadlet aligned, all four lanes enabled
   task automatic quad(input logic w, input logic [31:0] a);
      access(w, {a[31:2], 2'b00}, QUAD_BYTE_EN);
   endtask

   // Released qualifiers flip so a stale value never looks like a live request
   task automatic release_bus();
      @(negedge ref_clk_i);
      req_valid_o   = 1'b0;
      req_write_o   = ~req_write_o;
      req_addr_o    = ~req_addr_o;
      req_byte_en_o = ~req_byte_en_o;
   endtask
endmodule
